//--- dv/pc_card_model.sv
// pc card model: answers the strobes and stretches them with its wait pin.
// assumes active-low strobes and a pulled-up wait pin between accesses.
`timescale 1ns/1ps
`default_nettype none
module pc_card_model (
	// clock
	input  wire logic       aclk,
	// strobes from the host side
	input  wire logic       card_oe_n,
	input  wire logic       card_we_n,
	// cycles of wait asked for at each strobe
	input  wire logic [7:0] stall,
	output var logic        card_wait_n
);
	logic [7:0] cnt;

	initial begin
		cnt = 8'h00;
		card_wait_n = 1'b1;
	end

	// the pull-up wins whenever no strobe is being stretched
	always @(posedge aclk) begin
		if (card_oe_n & card_we_n) begin
			cnt <= 8'h00;
			card_wait_n <= 1'b1;
		end else begin
			cnt <= (cnt < stall) ? cnt + 8'h01 : cnt;
			card_wait_n <= !(cnt < stall);
		end
	end
endmodule
`default_nettype wire

//--- dv/test_pc_card_strobe_timing.sv
// testbench for the strobe timing block: register access over axi4-lite,
// then card accesses timed against the programmed delays and wait codes.
// assumes the card model of pc_card_model.sv on the card side.
`timescale 1ns/1ps
`default_nettype none
module test_pc_card_strobe_timing;
	logic        aclk, aresetn;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [3:0]  awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd;
	logic [1:0]  bresp, rresp, resp;
	logic        acc_valid, acc_ready, beat_done, card_wait_n;
	logic        card_addr_en, card_area6, card_oe_n, card_we_n;
	logic [7:0]  stall;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          beats, n_oe, n_we;
	realtime     t_au, t_sd, t_su, t_ad;
	pc_card_timing_pkg::acc_req_s acc;
	wire logic   strobe_n = card_oe_n & card_we_n;
	localparam int WT[16] = '{0, 1, 2, 3, 4, 6, 8, 10, 12, 14, 18, 22, 26, 30, 34, 38};

	pc_card_strobe_timing #(.ADDR_W(4)) DUT (
		.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
		.awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
		.rdata(rdata), .rresp(rresp), .acc_valid(acc_valid), .acc_ready(acc_ready),
		.acc(acc), .beat_done(beat_done), .card_wait_n(card_wait_n),
		.card_addr_en(card_addr_en), .card_area6(card_area6), .card_oe_n(card_oe_n),
		.card_we_n(card_we_n)
	);
	pc_card_model card (
		.aclk(aclk), .card_oe_n(card_oe_n), .card_we_n(card_we_n), .stall(stall),
		.card_wait_n(card_wait_n)
	);

	////////////////////////////////////////////////////////////////////////////
	always #25 aclk = ~aclk;
	// edge times in ns; half-cycle delays show as 25 ns offsets
	always @(posedge card_addr_en) t_au = $realtime;
	always @(negedge card_addr_en) t_ad = $realtime;
	always @(negedge strobe_n) t_sd = $realtime;
	always @(posedge strobe_n) t_su = $realtime;
	always @(negedge card_oe_n) n_oe++;
	always @(negedge card_we_n) n_we++;
	always @(posedge aclk) begin
		if (beat_done === 1'b1)
			beats++;
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			give_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [3:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rd = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// the idle area gets the inverted settings, so a swapped field shows
	task automatic run(input logic a6, input logic wr, input logic [1:0] ex,
			input logic [3:0] code, input logic [2:0] ted, input logic [2:0] teh,
			input logic [7:0] st, input logic ext);
		logic [3:0] c5, c6;
		logic [2:0] d5, d6, h5, h6;
		int         w, b, exp_w;
		{c5, d5, h5} = a6 ? ~{code, ted, teh} : {code, ted, teh};
		{c6, d6, h6} = a6 ? {code, ted, teh} : ~{code, ted, teh};
		w = WT[code];
		b = (code == 4'h0) ? 2 : w + 1;
		exp_w = 50 * (w + 1 + b * int'(ex));
		axi_write(4'h0, {16'h0000, c6[3], c5[3], 2'b00, d5[2], d6, d5[1:0], h5, h6}, 4'hF);
		axi_write(4'h4, {26'h0000000, c6[2:0], c5[2:0]}, 4'hF);
		stall <= st;
		beats = 0;
		n_oe = 0;
		n_we = 0;
		@(posedge aclk);
		acc_valid <= 1'b1;
		acc <= {a6, wr, ex};
		do @(posedge aclk); while (acc_ready !== 1'b1);
		acc_valid <= 1'b0;
		@(negedge card_addr_en);
		@(posedge aclk);
		check("assert delay", int'(t_sd - t_au), 50 * ted + 25);
		check("negate delay", int'(t_ad - t_su), 50 * teh + 25);
		if (ext)
			check("wait stretch", (t_su - t_sd) > exp_w, 32'h1);
		else
			check("strobe width", int'(t_su - t_sd), exp_w);
		check("beats", beats, ex + 1);
		check("oe count", n_oe, !wr);
		check("we count", n_we, wr);
		check("area", card_area6, a6);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, acc_valid} = 6'h00;
		{awaddr, araddr, wstrb} = 12'h000;
		wdata = 32'h00000000;
		acc = '0;
		stall = 8'h00;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(4'h0);
		check("timing reset", rd, 32'h00000000);
		axi_read(4'h4);
		check("wait2 reset", rd, 32'h00000000);
		// software keeps the reserved bits at zero
		axi_write(4'h0, 32'hFFFFCFFF, 4'hF);
		axi_read(4'h0);
		check("timing all ones", rd, 32'h0000CFFF);
		axi_write(4'h0, 32'h00000000, 4'h1);
		axi_read(4'h0);
		check("timing low lane", rd, 32'h0000CF00);
		axi_write(4'hC, 32'hFFFFFFFF, 4'hF);
		check("unmapped wr", resp, 32'h00000002);
		axi_read(4'hC);
		check("unmapped rd", {rd[29:0], resp}, 32'h00000002);
		// both areas act as pc card here, so either wait msb may be set
		run(1'b0, 1'b0, 2'h0, 4'h0, 3'h0, 3'h0, 8'h03, 1'b0);
		run(1'b1, 1'b1, 2'h0, 4'hF, 3'h7, 3'h6, 8'h00, 1'b0);
		axi_read(4'h8);
		check("status idle", rd, 32'h00000010);
		run(1'b0, 1'b1, 2'h1, 4'h9, 3'h5, 3'h7, 8'h00, 1'b0);
		run(1'b1, 1'b0, 2'h3, 4'h0, 3'h2, 3'h1, 8'h00, 1'b0);
		run(1'b0, 1'b0, 2'h0, 4'h1, 3'h1, 3'h3, 8'h05, 1'b1);
		axi_read(4'h4);
		check("wait2 value", rd, 32'h00000031);
		// a second reset in mid-run must clear the registers again
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		axi_read(4'h0);
		check("timing after reset", rd, 32'h00000000);
		give_verdict();
	end
endmodule
`default_nettype wire

//--- rtl/pc_card_strobe_timing.sv
// pc card strobe timing engine for areas 5 and 6 with its register file.
// assumes one 20 MHz bus clock, synchronous active-low reset, axi4-lite
// master on the register port and an access requester on the user side.
`timescale 1ns/1ps
`default_nettype none

module pc_card_strobe_timing #(
	parameter int ADDR_W = 4
) (
	// clock and reset
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	// axi4-lite write
	input  wire logic                        awvalid,
	output logic                             awready,
	input  wire logic [ADDR_W-1:0]           awaddr,
	input  wire logic                        wvalid,
	output logic                             wready,
	input  wire logic [31:0]                 wdata,
	input  wire logic [3:0]                  wstrb,
	output logic                             bvalid,
	input  wire logic                        bready,
	output logic [1:0]                       bresp,
	// axi4-lite read
	input  wire logic                        arvalid,
	output logic                             arready,
	input  wire logic [ADDR_W-1:0]           araddr,
	output logic                             rvalid,
	input  wire logic                        rready,
	output logic [31:0]                      rdata,
	output logic [1:0]                       rresp,
	// access requests
	input  wire logic                        acc_valid,
	output logic                             acc_ready,
	input  wire pc_card_timing_pkg::acc_req_s acc,
	output logic                             beat_done,
	// pc card side
	input  wire logic                        card_wait_n,
	output logic                             card_addr_en,
	output logic                             card_area6,
	output logic                             card_oe_n,
	output logic                             card_we_n
);

	function automatic pc_card_timing_pkg::reg_sel_e decode(input logic [ADDR_W-1:0] a);
		logic [3:0] w;
		w = 4'(a);
		// bits above the map never alias onto a register; bits 1:0 are ignored
		if ((a >> 4) != '0)
			decode = pc_card_timing_pkg::SEL_NONE;
		else if (w[3:2] == pc_card_timing_pkg::OFF_TIMING[3:2])
			decode = pc_card_timing_pkg::SEL_TIMING;
		else if (w[3:2] == pc_card_timing_pkg::OFF_WAIT2[3:2])
			decode = pc_card_timing_pkg::SEL_WAIT2;
		else if (w[3:2] == pc_card_timing_pkg::OFF_STATUS[3:2])
			decode = pc_card_timing_pkg::SEL_STATUS;
		else
			decode = pc_card_timing_pkg::SEL_NONE;
	endfunction

	function automatic logic [5:0] waits_of(input logic [3:0] code);
		waits_of = pc_card_timing_pkg::WAIT_TABLE[code];
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// axi write channel: address and data taken in either order
	logic                   aw_held, next_aw_held, w_held, next_w_held;
	logic [ADDR_W-1:0]      wr_addr, awaddr_q;
	logic [31:0]            wr_data, wdata_q;
	logic [3:0]             wr_strb, wstrb_q;
	logic                   wr_fire;
	logic                   next_bvalid, next_awready, next_wready;
	logic [1:0]             next_bresp;

	always_comb begin
		next_aw_held = aw_held;
		wr_addr      = awaddr_q;
		next_w_held  = w_held;
		wr_data      = wdata_q;
		wr_strb      = wstrb_q;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			wr_addr      = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held = 1'b1;
			wr_data     = wdata;
			wr_strb     = wstrb;
		end
		if (bvalid && bready)
			next_bvalid = 1'b0;
		wr_fire = next_aw_held && next_w_held && !bvalid;
		if (wr_fire) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = (decode(wr_addr) == pc_card_timing_pkg::SEL_NONE)
				? pc_card_timing_pkg::RESP_SLVERR : pc_card_timing_pkg::RESP_OKAY;
		end
		next_awready = !next_aw_held && !next_bvalid;
		next_wready  = !next_w_held && !next_bvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			w_held   <= 1'b0;
			awaddr_q <= '0;
			wdata_q  <= 32'h00000000;
			wstrb_q  <= 4'h0;
			bvalid   <= 1'b0;
			bresp    <= 2'h0;
			awready  <= 1'b1;
			wready   <= 1'b1;
		end else begin
			aw_held  <= next_aw_held;
			w_held   <= next_w_held;
			awaddr_q <= wr_addr;
			wdata_q  <= wr_data;
			wstrb_q  <= wr_strb;
			bvalid   <= next_bvalid;
			bresp    <= next_bresp;
			awready  <= next_awready;
			wready   <= next_wready;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register file
	logic [15:0] pc_card_strobe_timing, next_pc_card_strobe_timing;
	logic [5:0]  wait2, next_wait2;

	always_comb begin
		next_pc_card_strobe_timing = pc_card_strobe_timing;
		next_wait2                 = wait2;
		if (wr_fire) begin
			unique case (decode(wr_addr))
				pc_card_timing_pkg::SEL_TIMING: begin
					if (wr_strb[0])
						next_pc_card_strobe_timing[7:0] = wr_data[7:0];
					if (wr_strb[1])
						next_pc_card_strobe_timing[15:8] = wr_data[15:8];
					next_pc_card_strobe_timing = next_pc_card_strobe_timing
						& pc_card_timing_pkg::TIMING_RW_MASK;
				end
				pc_card_timing_pkg::SEL_WAIT2: begin
					if (wr_strb[0])
						next_wait2 = wr_data[5:0];
				end
				pc_card_timing_pkg::SEL_STATUS: ;
				pc_card_timing_pkg::SEL_NONE: ;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pc_card_strobe_timing <= pc_card_timing_pkg::TIMING_RESET;
			wait2                 <= pc_card_timing_pkg::WAIT2_RESET;
		end else begin
			pc_card_strobe_timing <= next_pc_card_strobe_timing;
			wait2                 <= next_wait2;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi read channel, answered one cycle after the address is taken
	pc_card_timing_pkg::fsm_state_e state, next_state;
	pc_card_timing_pkg::acc_req_s   req, next_req;
	logic                           next_rvalid, next_arready;
	logic [31:0]                    next_rdata;
	logic [1:0]                     next_rresp;

	always_comb begin
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rresp  = pc_card_timing_pkg::RESP_OKAY;
			unique case (decode(araddr))
				pc_card_timing_pkg::SEL_TIMING:
					next_rdata = {16'h0000, pc_card_strobe_timing};
				pc_card_timing_pkg::SEL_WAIT2:  next_rdata = {26'h0000000, wait2};
				pc_card_timing_pkg::SEL_STATUS:
					next_rdata = {27'h0000000, req.area6, state, 1'b0, card_addr_en};
				pc_card_timing_pkg::SEL_NONE: begin
					next_rdata = 32'h00000000;
					next_rresp = pc_card_timing_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= 2'h0;
			arready <= 1'b1;
		end else begin
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
			arready <= next_arready;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// access sequencer; timing is latched at the start so that register
	// writes during an access only affect the next one
	pc_card_timing_pkg::timing_s tim, next_tim, sel_tim;
	logic [5:0] cnt, next_cnt;
	logic [1:0] beats, next_beats;
	logic       strobe_cmd, next_strobe_cmd;
	logic       next_addr_en, next_beat_done, next_acc_ready;
	logic       first_beat, wait_on;

	always_comb begin
		if (acc.area6) begin
			sel_tim.code = {pc_card_strobe_timing[pc_card_timing_pkg::A6_WAIT_MSB],
				wait2[pc_card_timing_pkg::A6_LOW_LSB +: 3]};
			sel_tim.ted  = pc_card_strobe_timing[pc_card_timing_pkg::A6_TED_LSB +: 3];
			sel_tim.teh  = pc_card_strobe_timing[pc_card_timing_pkg::A6_TEH_LSB +: 3];
		end else begin
			sel_tim.code = {pc_card_strobe_timing[pc_card_timing_pkg::A5_WAIT_MSB],
				wait2[pc_card_timing_pkg::A5_LOW_LSB +: 3]};
			sel_tim.ted  = {pc_card_strobe_timing[pc_card_timing_pkg::A5_TED_B2],
				pc_card_strobe_timing[pc_card_timing_pkg::A5_TED_B1],
				pc_card_strobe_timing[pc_card_timing_pkg::A5_TED_B0]};
			sel_tim.teh  = pc_card_strobe_timing[pc_card_timing_pkg::A5_TEH_LSB +: 3];
		end
		first_beat      = (beats == req.extra_beats);
		// the wait pin is ignored while programmed waits remain and in a zero-wait first datum
		wait_on         = !card_wait_n && !(first_beat && tim.code == 4'h0);
		next_state      = state;
		next_req        = req;
		next_tim        = tim;
		next_cnt        = cnt;
		next_beats      = beats;
		next_strobe_cmd = strobe_cmd;
		next_addr_en    = card_addr_en;
		next_beat_done  = 1'b0;
		unique case (state)
			pc_card_timing_pkg::ST_IDLE: begin
				if (acc_valid && acc_ready) begin
					next_req     = acc;
					next_tim     = sel_tim;
					next_beats   = acc.extra_beats;
					next_addr_en = 1'b1;
					if (sel_tim.ted == 3'h0) begin
						next_strobe_cmd = 1'b1;
						next_cnt        = waits_of(sel_tim.code);
						next_state      = pc_card_timing_pkg::ST_STROBE;
					end else begin
						next_cnt   = {3'h0, sel_tim.ted} - 6'h01;
						next_state = pc_card_timing_pkg::ST_SETUP;
					end
				end
			end
			pc_card_timing_pkg::ST_SETUP: begin
				if (cnt == 6'h00) begin
					next_strobe_cmd = 1'b1;
					next_cnt        = waits_of(tim.code);
					next_state      = pc_card_timing_pkg::ST_STROBE;
				end else
					next_cnt = cnt - 6'h01;
			end
			pc_card_timing_pkg::ST_STROBE: begin
				if (cnt != 6'h00)
					next_cnt = cnt - 6'h01;
				else if (!wait_on) begin
					next_beat_done = 1'b1;
					if (beats != 2'h0) begin
						next_beats = beats - 2'h1;
						next_cnt   = ((tim.code == 4'h0) ? pc_card_timing_pkg::BURST_ZERO_CODE
							: waits_of(tim.code) + 6'h01) - 6'h01;
					end else begin
						next_strobe_cmd = 1'b0;
						next_cnt        = {3'h0, tim.teh};
						next_state      = pc_card_timing_pkg::ST_HOLD;
					end
				end
			end
			pc_card_timing_pkg::ST_HOLD: begin
				if (cnt == 6'h00) begin
					next_addr_en = 1'b0;
					next_state   = pc_card_timing_pkg::ST_IDLE;
				end else
					next_cnt = cnt - 6'h01;
			end
		endcase
		next_acc_ready = (next_state == pc_card_timing_pkg::ST_IDLE);
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state        <= pc_card_timing_pkg::ST_IDLE;
			req          <= '0;
			tim          <= '0;
			cnt          <= 6'h00;
			beats        <= 2'h0;
			strobe_cmd   <= 1'b0;
			card_addr_en <= 1'b0;
			beat_done    <= 1'b0;
			acc_ready    <= 1'b1;
		end else begin
			state        <= next_state;
			req          <= next_req;
			tim          <= next_tim;
			cnt          <= next_cnt;
			beats        <= next_beats;
			strobe_cmd   <= next_strobe_cmd;
			card_addr_en <= next_addr_en;
			beat_done    <= next_beat_done;
			acc_ready    <= next_acc_ready;
		end
	end

	assign card_area6 = req.area6;

	////////////////////////////////////////////////////////////////////////////
	// strobes launched on the falling edge give the half-cycle offsets
	logic next_oe_n, next_we_n;

	always_comb begin
		next_oe_n = !(strobe_cmd && !req.write);
		next_we_n = !(strobe_cmd && req.write);
	end

	always_ff @(negedge aclk) begin
		if (!aresetn) begin
			card_oe_n <= 1'b1;
			card_we_n <= 1'b1;
		end else begin
			card_oe_n <= next_oe_n;
			card_we_n <= next_we_n;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	logic [7:0] since_addr, since_on, since_off;
	logic [7:0] next_since_addr, next_since_on, next_since_off;

	always_comb begin
		next_since_addr = card_addr_en ? since_addr + 8'h01 : 8'h00;
		next_since_on   = strobe_cmd ? since_on + 8'h01 : 8'h00;
		next_since_off  = (state == pc_card_timing_pkg::ST_HOLD) ? since_off + 8'h01 : 8'h00;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			since_addr <= 8'h00;
			since_on   <= 8'h00;
			since_off  <= 8'h00;
		end else begin
			since_addr <= next_since_addr;
			since_on   <= next_since_on;
			since_off  <= next_since_off;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_strobe_rise;
		$rose(strobe_cmd);
	endsequence
	sequence s_addr_fall;
		$fell(card_addr_en);
	endsequence

	a_timing_write_kept: assert property (
		(wr_fire && decode(wr_addr) == pc_card_timing_pkg::SEL_TIMING
			&& wr_strb[1:0] == 2'h3)
		|=> pc_card_strobe_timing
			== (16'($past(wr_data)) & pc_card_timing_pkg::TIMING_RW_MASK))
		else $error("timing register did not take written value");
	a_reserved_read_zero: assert property (
		(arvalid && arready && decode(araddr) == pc_card_timing_pkg::SEL_TIMING)
		|=> rvalid && rdata[13:12] == 2'h0)
		else $error("reserved bits read nonzero");
	a_wait_code_msb: assert property (
		(acc_valid && acc_ready) |=> tim.code == (req.area6
			? {$past(pc_card_strobe_timing[15]), $past(wait2[5:3])}
			: {$past(pc_card_strobe_timing[14]), $past(wait2[2:0])}))
		else $error("wait code not joined from both registers");
	a_a5_assert_delay: assert property (
		s_strobe_rise ##0 !req.area6 |-> since_addr == {5'h00, tim.ted})
		else $error("area 5 assert delay wrong");
	a_a6_assert_delay: assert property (
		s_strobe_rise ##0 req.area6 |-> since_addr == {5'h00, tim.ted})
		else $error("area 6 assert delay wrong");
	a_assert_bounded: assert property (
		$rose(card_addr_en) |-> ##[0:7] $rose(strobe_cmd))
		else $error("strobe not asserted within delay range");
	a_a5_negate_delay: assert property (
		s_addr_fall ##0 !req.area6 |-> since_off == {5'h00, tim.teh} + 8'h01)
		else $error("area 5 negate delay wrong");
	a_a6_negate_delay: assert property (
		s_addr_fall ##0 req.area6 |-> since_off == {5'h00, tim.teh} + 8'h01)
		else $error("area 6 negate delay wrong");
	a_zero_wait_width: assert property (
		$fell(strobe_cmd) && tim.code == 4'h0 && $past(card_wait_n)
		|-> since_on == 8'h01 + {6'h00, req.extra_beats} * 8'h02)
		else $error("zero wait code strobe width wrong");
	// sampled on the falling edge: a strobe launched on the rising edge would already be low
	a_half_cycle_edge: assert property (
		@(negedge aclk) $rose(strobe_cmd)
		|-> (card_oe_n && card_we_n) ##1 !(card_oe_n && card_we_n))
		else $error("strobe not launched on falling edge");

endmodule

`default_nettype wire

//--- rtl/pc_card_timing_pkg.sv
// package for the pc card strobe timing block: register map, field layout,
// reset values, wait code table and state encoding.
// assumes a single bus clock and a 32-bit axi4-lite register port.
`default_nettype none

package pc_card_timing_pkg;

	////////////////////////////////////////////////////////////////////////////
	// register map (byte offsets)
	localparam logic [3:0]  OFF_TIMING    = 4'h0;
	localparam logic [3:0]  OFF_WAIT2     = 4'h4;
	localparam logic [3:0]  OFF_STATUS    = 4'h8;

	localparam logic [15:0] TIMING_RESET   = 16'h0000;
	localparam logic [5:0]  WAIT2_RESET    = 6'h00;
	localparam logic [15:0] TIMING_RW_MASK = 16'hCFFF;

	// timing register fields
	localparam int A6_WAIT_MSB  = 15;
	localparam int A5_WAIT_MSB  = 14;
	localparam int RSVD_LSB     = 12;
	localparam int A5_TED_B2    = 11;
	localparam int A6_TED_LSB   = 8;
	localparam int A5_TED_B1    = 7;
	localparam int A5_TED_B0    = 6;
	localparam int A5_TEH_LSB   = 3;
	localparam int A6_TEH_LSB   = 0;

	// wait control two fields
	localparam int A5_LOW_LSB   = 0;
	localparam int A6_LOW_LSB   = 3;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////
	// first-cycle wait states per four-bit code; burst states are the same,
	// except code zero which uses the burst minimum
	localparam logic [5:0] WAIT_TABLE [0:15] = '{
		6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h08, 6'h0A,
		6'h0C, 6'h0E, 6'h12, 6'h16, 6'h1A, 6'h1E, 6'h22, 6'h26
	};
	localparam logic [5:0] BURST_ZERO_CODE = 6'h02;

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [1:0] {
		SEL_TIMING = 2'h0,
		SEL_WAIT2  = 2'h1,
		SEL_STATUS = 2'h2,
		SEL_NONE   = 2'h3
	} reg_sel_e;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'h0,
		ST_SETUP  = 2'h1,
		ST_STROBE = 2'h3,
		ST_HOLD   = 2'h2
	} fsm_state_e;

	typedef struct packed {
		logic       area6;
		logic       write;
		logic [1:0] extra_beats;
	} acc_req_s;

	typedef struct packed {
		logic [3:0] code;
		logic [2:0] ted;
		logic [2:0] teh;
	} timing_s;

endpackage

`default_nettype wire
